// *** srb_consts.svh ***
`ifndef SRB_CONSTS_SVH
`define SRB_CONSTS_SVH
// register offsets on the peripheral bus
`define SRB_OFS_CTRL 4'h0
`define SRB_OFS_STAT 4'h1
`define SRB_OFS_DATA 4'h2
`define SRB_OFS_FCNT 4'h3
// status field positions
`define SRB_ST_FULL 7
`define SRB_ST_RSVD 6
`define SRB_ST_TXE 5
`define SRB_ST_OVR 0
// control field positions (interrupt enables)
`define SRB_CT_RXIE 0
`define SRB_CT_TXIE 1
`define SRB_CT_ERIE 2
// reset values
`define SRB_CTRL_RST 8'h00
`define SRB_FCNT_RST 8'h00
`define SRB_DATA_RST 8'h00
`endif

// *** srb_pkg.sv ***
package srb_pkg;
  // receive state, gray coded
  typedef enum logic [1:0] {
    SRB_IDLE = 2'b00,
    SRB_SHIFT = 2'b01
  } srb_state_t;
  // sticky status flags
  typedef struct packed {
    logic full;
    logic ovr;
  } srb_flags_t;
  // peripheral bus request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } srb_req_t;
endpackage

// *** srb_rx_status.sv ***
//////////////////////////////////////////////////////////////////////////////
// Contract
// R1: full flag at status bit 7, reset 0
// R2: completed transfer loads data, sets flag
// R3: flag set means last bit shifted
// R4: transfer ending while full not loaded
// R5: overrun blocks flag rising
// R6: clear needs read-one then write-zero
// R7: dma frame-count reads clear flag
// R8: controller reads clear, except zero-count end-select
// R9: flag sets after frame-count frames received
// R10: three maskable interrupt requests
// R11: status bit 6 reads zero
// R12: registers reached through peripheral bus
// R13: writing one to flag does nothing
//////////////////////////////////////////////////////////////////////////////
`include "srb_consts.svh"
module srb_rx_status
  import srb_pkg::*;
#(
  parameter int DW = 8,
  parameter int FRAMES = 4
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire srb_req_t pbus_req_in,
  output logic [7:0] pbus_rdata_out,
  input wire logic dma_rd_in,
  input wire logic xctl_rd_in,
  input wire logic xctl_cnt_zero_in,
  input wire logic xctl_end_sel_in,
  input wire logic tx_empty_in,
  input wire logic mode_fault_in,
  input wire logic sck_in,
  input wire logic ss_n_in,
  input wire logic mosi_in,
  output logic rx_irq_out,
  output logic tx_irq_out,
  output logic err_irq_out
);
  localparam int IW = $clog2(FRAMES);
  localparam int BW = $clog2(DW);

  srb_flags_t flags_reg;
  srb_state_t state_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] fcnt_reg;
  logic [DW-1:0] rx_buf_reg [FRAMES];
  logic [DW-1:0] shift_reg;
  logic [BW-1:0] bit_cnt_reg;
  logic [IW-1:0] wr_idx_reg;
  logic [IW-1:0] rd_idx_reg;
  logic armed_reg;
  logic [2:0] sck_sync_reg;
  logic [1:0] ss_sync_reg, mosi_sync_reg;
  logic sck_rise, frame_done, load_ok, set_full, clr_full, set_ovr;
  logic cpu_rd_data, any_rd_data, last_read, last_frame;
  logic [IW-1:0] frames_m1;

  // last index in use for the configured frame count
  function automatic logic [IW-1:0] last_idx(input logic [7:0] fc);
    last_idx = (fc > 8'(FRAMES - 1)) ? IW'(FRAMES - 1) : fc[IW-1:0];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // link input synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sck_sync_reg <= 3'h0;
      ss_sync_reg <= 2'h3;
      mosi_sync_reg <= 2'h0;
    end else begin
      sck_sync_reg <= {sck_sync_reg[1:0], sck_in};
      ss_sync_reg <= {ss_sync_reg[0], ss_n_in};
      mosi_sync_reg <= {mosi_sync_reg[0], mosi_in};
    end
  end

  assign sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2] & ~ss_sync_reg[1];

  //////////////////////////////////////////////////////////////////////////
  // shift engine: one word per DW sampled clock edges
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= SRB_IDLE;
      shift_reg <= '0;
      bit_cnt_reg <= '0;
    end else begin
      case (state_reg)
        SRB_IDLE: begin
          bit_cnt_reg <= '0;
          if (!ss_sync_reg[1]) begin
            state_reg <= SRB_SHIFT;
          end
        end
        SRB_SHIFT: begin
          if (ss_sync_reg[1]) begin
            state_reg <= SRB_IDLE;
          end else if (sck_rise) begin
            shift_reg <= {shift_reg[DW-2:0], mosi_sync_reg[1]};
            bit_cnt_reg <= (bit_cnt_reg == BW'(DW - 1)) ? '0 :
                           bit_cnt_reg + 1'b1;
          end
        end
        default: state_reg <= SRB_IDLE;
      endcase
    end
  end

  // the received word is complete once its last bit is in
  assign frame_done = (state_reg == SRB_SHIFT) & sck_rise &
                      (bit_cnt_reg == BW'(DW - 1)); // R3
  assign load_ok = frame_done & ~flags_reg.full & ~flags_reg.ovr; // R4 R5
  assign frames_m1 = last_idx(fcnt_reg);
  assign last_frame = (wr_idx_reg == frames_m1);
  assign set_full = load_ok & last_frame; // R2 R9
  assign set_ovr = frame_done & flags_reg.full; // R4

  //////////////////////////////////////////////////////////////////////////
  // receive buffer, written only while the flag is low
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_idx_reg <= '0;
      for (int i = 0; i < FRAMES; i++) begin
        rx_buf_reg[i] <= '0;
      end
    end else if (load_ok) begin
      rx_buf_reg[wr_idx_reg] <= {shift_reg[DW-2:0], mosi_sync_reg[1]}; // R2
      wr_idx_reg <= last_frame ? '0 : wr_idx_reg + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // data reads by cpu, dma or transfer controller walk the buffer
  assign cpu_rd_data = pbus_req_in.rd & (pbus_req_in.addr == `SRB_OFS_DATA);
  assign any_rd_data = cpu_rd_data | dma_rd_in | xctl_rd_in;
  assign last_read = (rd_idx_reg == frames_m1);

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_idx_reg <= '0;
    end else if (set_full) begin
      rd_idx_reg <= '0;
    end else if (any_rd_data && flags_reg.full) begin
      rd_idx_reg <= last_read ? '0 : rd_idx_reg + 1'b1;
    end
  end

  // read-then-write clear: arming follows a status read showing one
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      armed_reg <= 1'b0;
    end else if (pbus_req_in.rd && pbus_req_in.addr == `SRB_OFS_STAT) begin
      armed_reg <= flags_reg.full; // R6
    end else if (clr_full || !flags_reg.full) begin // no stale arming
      armed_reg <= 1'b0;
    end
  end

  assign clr_full = flags_reg.full & (
    (pbus_req_in.wr && pbus_req_in.addr == `SRB_OFS_STAT &&
     !pbus_req_in.wdata[`SRB_ST_FULL] && armed_reg) | // R6 R13
    (dma_rd_in & last_read) | // R7
    (xctl_rd_in & last_read & ~(xctl_cnt_zero_in & xctl_end_sel_in))); // R8

  //////////////////////////////////////////////////////////////////////////
  // sticky flags; a set in the clearing cycle wins
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flags_reg <= '0; // R1
    end else begin
      if (set_full) begin
        flags_reg.full <= 1'b1; // R2 R9
      end else if (clr_full) begin
        flags_reg.full <= 1'b0;
      end
      if (set_ovr) begin
        flags_reg.ovr <= 1'b1;
      end else if (pbus_req_in.wr && pbus_req_in.addr == `SRB_OFS_STAT &&
                   !pbus_req_in.wdata[`SRB_ST_OVR]) begin
        flags_reg.ovr <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control and frame count registers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_reg <= `SRB_CTRL_RST;
      fcnt_reg <= `SRB_FCNT_RST;
    end else if (pbus_req_in.wr) begin
      if (pbus_req_in.addr == `SRB_OFS_CTRL) begin
        ctrl_reg <= pbus_req_in.wdata; // R12
      end
      if (pbus_req_in.addr == `SRB_OFS_FCNT) begin
        fcnt_reg <= pbus_req_in.wdata;
      end
    end
  end

  // registered read data, one cycle after the strobe
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pbus_rdata_out <= 8'h00;
    end else if (pbus_req_in.rd) begin
      case (pbus_req_in.addr)
        `SRB_OFS_CTRL: pbus_rdata_out <= ctrl_reg;
        `SRB_OFS_STAT: begin
          pbus_rdata_out <= 8'h00; // R11
          pbus_rdata_out[`SRB_ST_FULL] <= flags_reg.full; // R1
          pbus_rdata_out[`SRB_ST_TXE] <= tx_empty_in;
          pbus_rdata_out[`SRB_ST_OVR] <= flags_reg.ovr;
        end
        `SRB_OFS_DATA: pbus_rdata_out <= 8'(rx_buf_reg[rd_idx_reg]);
        `SRB_OFS_FCNT: pbus_rdata_out <= fcnt_reg;
        default: pbus_rdata_out <= 8'h00;
      endcase
    end
  end

  // maskable interrupt requests
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_irq_out <= 1'b0;
      tx_irq_out <= 1'b0;
      err_irq_out <= 1'b0;
    end else begin
      rx_irq_out <= flags_reg.full & ctrl_reg[`SRB_CT_RXIE]; // R10
      tx_irq_out <= tx_empty_in & ctrl_reg[`SRB_CT_TXIE]; // R10
      err_irq_out <= (flags_reg.ovr | mode_fault_in) &
                     ctrl_reg[`SRB_CT_ERIE]; // R10
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  a_full_sets: assert property (set_full |=> flags_reg.full) // R2
    else $error("full flag not set after last frame");
  a_no_load_full: assert property ( // R4
    frame_done && flags_reg.full
    |=> $stable(wr_idx_reg) && $stable(rx_buf_reg[wr_idx_reg]))
    else $error("buffer changed while full");
  a_ovr_blocks: assert property ( // R5
    flags_reg.ovr && !flags_reg.full |=> !flags_reg.full)
    else $error("full flag rose during overrun");
  a_clear_armed: assert property ( // R6
    $fell(flags_reg.full) && !$past(dma_rd_in) && !$past(xctl_rd_in)
    |-> $past(armed_reg))
    else $error("cpu clear without prior read");
  a_set_only_hw: assert property ( // R13
    $rose(flags_reg.full) |-> $past(set_full))
    else $error("full flag set without reception");
  a_dma_clear: assert property ( // R7
    dma_rd_in && last_read && flags_reg.full && !set_full
    |=> !flags_reg.full)
    else $error("dma count did not clear flag");
  a_xctl_keep: assert property ( // R8
    xctl_rd_in && xctl_cnt_zero_in && xctl_end_sel_in && !dma_rd_in &&
    !pbus_req_in.wr && flags_reg.full |=> flags_reg.full)
    else $error("controller cleared flag at zero count");
  a_rsvd_zero: assert property ( // R11
    pbus_req_in.rd && pbus_req_in.addr == `SRB_OFS_STAT
    |=> !pbus_rdata_out[`SRB_ST_RSVD])
    else $error("reserved bit read as one");
  a_rx_irq: assert property ( // R10
    flags_reg.full && ctrl_reg[`SRB_CT_RXIE] |=> rx_irq_out)
    else $error("receive interrupt missing");

  c_full: cover property ($rose(flags_reg.full));
  c_ovr: cover property ($rose(flags_reg.ovr));
  c_cpu_clr: cover property ($fell(flags_reg.full) && $past(armed_reg));
  c_dma_clr: cover property (dma_rd_in && last_read && flags_reg.full);
endmodule // srb_rx_status

// *** srb_spi_peer.sv ***
//////////////////////////////
// serial peer that drives the link as master
module srb_spi_peer (
  output logic sck_out,
  output logic ss_n_out,
  output logic mosi_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // link idle: clock stands low, select released high
  initial begin
    sck_out = 1'b0;
    ss_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // one frame of n bits, msb first, 80 ns per bit; fewer than 8 cut it
  task automatic send(input logic [7:0] b, input int n = 8);
    #1.3 ss_n_out = 1'b0;
    for (int i = 7; i > 7 - n; i--) begin
      mosi_out = b[i];
      #40 sck_out = 1'b1;
      #40 sck_out = 1'b0;
    end
    #20 ss_n_out = 1'b1;
    mosi_out = ~mosi_out; // released line never shows the last bit
  endtask
endmodule // srb_spi_peer

// *** tb_srb_rx_status.sv ***
`include "srb_consts.svh"
//////////////////////////////
module tb_srb_rx_status;
  timeunit 1ns;
  timeprecision 100ps;
  import srb_pkg::*;
  logic clk_in, sys_rst_in, dma_rd, xctl_rd, xctl_zero, xctl_sel;
  logic tx_empty, mode_fault;
  logic sck, ss_n, mosi, rx_irq, tx_irq, err_irq;
  logic [7:0] rdata, got;
  srb_req_t req;
  int bad_count, checks_done;
  srb_rx_status #(.DW(8), .FRAMES(4)) dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .pbus_req_in(req),
    .pbus_rdata_out(rdata), .dma_rd_in(dma_rd), .xctl_rd_in(xctl_rd),
    .xctl_cnt_zero_in(xctl_zero), .xctl_end_sel_in(xctl_sel),
    .tx_empty_in(tx_empty), .mode_fault_in(mode_fault), .sck_in(sck),
    .ss_n_in(ss_n), .mosi_in(mosi), .rx_irq_out(rx_irq),
    .tx_irq_out(tx_irq), .err_irq_out(err_irq)
  );
  srb_spi_peer u_peer (.sck_out(sck), .ss_n_out(ss_n), .mosi_out(mosi));
  // 250 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  //////////////////////////////
  // compare and count
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one-cycle bus strobes, launched just after the edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in) #1;
    req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk_in) #1;
    req.wr = 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [3:0] a,
                      input logic [7:0] e);
    @(posedge clk_in) #1;
    req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk_in) #1;
    req.rd = 1'b0;
    got = rdata;
    chk(nm, e, got);
  endtask
  // a frame from the peer, then time for the sync and the load
  task automatic frame(input logic [7:0] b, input int n = 8);
    u_peer.send(b, n);
    repeat (12) @(posedge clk_in);
    #1;
  endtask
  task automatic rx_irq_is(input logic e);
    chk("rx_irq", {7'h00, e}, {7'h00, rx_irq});
  endtask
  // single read pulse from dma or the transfer controller
  task automatic pulse(input logic from_xctl);
    @(posedge clk_in) #1;
    {xctl_rd, dma_rd} = from_xctl ? 2'b10 : 2'b01;
    @(posedge clk_in) #1;
    {xctl_rd, dma_rd} = 2'b00;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  //////////////////////////////
  // watchdog against a hung run
  initial begin
    #100000;
    bad_count++;
    summarize();
  end
  // main sequence
  initial begin
    sys_rst_in = 1'b1;
    req = '0;
    {dma_rd, xctl_rd, xctl_zero, xctl_sel} = 4'h0;
    tx_empty = 1'b1;
    mode_fault = 1'b0;
    repeat (6) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    rchk("status", `SRB_OFS_STAT, 8'h20);
    rchk("ctrl", `SRB_OFS_CTRL, `SRB_CTRL_RST);
    rchk("unmapped", 4'hf, 8'h00);
    wr(`SRB_OFS_CTRL, 8'h07);
    wr(`SRB_OFS_FCNT, 8'h00);
    frame(8'ha5);
    rx_irq_is(1'b1);
    chk("tx_irq", 8'h01, {7'h00, tx_irq});
    chk("err_irq", 8'h00, {7'h00, err_irq});
    // clear attempts without a read, and a write of one
    wr(`SRB_OFS_STAT, 8'h00);
    wr(`SRB_OFS_STAT, 8'h80);
    rchk("status", `SRB_OFS_STAT, 8'ha0);
    wr(`SRB_OFS_STAT, 8'h00);
    rchk("status", `SRB_OFS_STAT, 8'h20);
    rchk("data", `SRB_OFS_DATA, 8'ha5);
    // a second frame while full is dropped and flags overrun
    frame(8'h11);
    frame(8'h22);
    rchk("status", `SRB_OFS_STAT, 8'ha1);
    chk("err_irq", 8'h01, {7'h00, err_irq});
    rchk("data", `SRB_OFS_DATA, 8'h11);
    wr(`SRB_OFS_STAT, 8'h01);
    frame(8'h33);
    rchk("status", `SRB_OFS_STAT, 8'h21);
    wr(`SRB_OFS_STAT, 8'h00);
    // a cut frame is dropped and the next one starts clean
    frame(8'hf0, 4);
    frame(8'h44);
    rchk("data", `SRB_OFS_DATA, 8'h44);
    rchk("status", `SRB_OFS_STAT, 8'ha0);
    chk("err_irq", 8'h00, {7'h00, err_irq});
    // mode fault alone raises the error request
    mode_fault = 1'b1;
    wr(`SRB_OFS_STAT, 8'h00);
    chk("err_irq", 8'h01, {7'h00, err_irq});
    mode_fault = 1'b0;
    tx_empty = 1'b0;
    // two-frame count drained by dma reads
    wr(`SRB_OFS_FCNT, 8'h01);
    chk("tx_irq", 8'h00, {7'h00, tx_irq});
    chk("err_irq", 8'h00, {7'h00, err_irq});
    frame(8'h55);
    rx_irq_is(1'b0);
    frame(8'h66);
    rx_irq_is(1'b1);
    pulse(1'b0);
    rx_irq_is(1'b1);
    pulse(1'b0);
    rx_irq_is(1'b0);
    // controller read blocked at zero count with end select, then clears
    wr(`SRB_OFS_FCNT, 8'h00);
    frame(8'h77);
    {xctl_zero, xctl_sel} = 2'b11;
    pulse(1'b1);
    rx_irq_is(1'b1);
    xctl_zero = 1'b0;
    pulse(1'b1);
    rx_irq_is(1'b0);
    rchk("status", `SRB_OFS_STAT, 8'h00);
    summarize();
  end
endmodule // tb_srb_rx_status
